// file: pkg/adc_scan_pkg.sv
// shared constants of the dual converter scan controller
package adc_scan_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int RES_WIDTH = 12;
  localparam int CHAN_WIDTH = 3;
  localparam int SLOT_COUNT = 8;
  localparam int LIST_WIDTH = SLOT_COUNT * CHAN_WIDTH;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LIST = 8'h0C;
  localparam logic [7:0] OFS_ZC_MODE = 8'h10;
  localparam logic [7:0] OFS_ZERO_LEVEL = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_LOW = 8'h40;
  localparam logic [7:0] OFS_HIGH = 8'h60;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_SIMUL_POS = 2;
  localparam int CTRL_START_POS = 3;
  localparam int CTRL_STOP_POS = 4;
  localparam int CTRL_LAST_POS = 5;
  localparam int CTRL_LIMIT_EN_POS = 8;
  localparam int CTRL_ZC_EN_POS = 9;
  localparam int STAT_EOS_POS = 0;
  localparam int STAT_LIMIT_POS = 1;
  localparam int STAT_ZC_POS = 2;
  localparam int STAT_BUSY_POS = 8;
  localparam int FLAGS_HIGH_POS = 8;
  localparam int FLAGS_ZC_POS = 16;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ONCE = 2'h0;
  localparam logic [1:0] MODE_TRIGGERED = 2'h1;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [1:0] ZC_OFF = 2'h0;
  localparam logic [1:0] ZC_RISING = 2'h1;
  localparam logic [1:0] ZC_FALLING = 2'h2;
  localparam logic [1:0] ZC_ANY = 2'h3;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [23:0] LIST_RESET = 24'hFAC688;
  localparam logic [15:0] ZC_MODE_RESET = 16'h0000;
  localparam logic [11:0] ZERO_LEVEL_RESET = 12'h800;
  localparam logic [11:0] LOW_RESET = 12'h000;
  localparam logic [11:0] HIGH_RESET = 12'hFFF;
  localparam logic [2:0] LAST_RESET = 3'h7;

endpackage

// file: verilog/adc_conv_port.sv
// start and capture handshake towards one sample-and-hold path and its converter
`timescale 1ns/1ps
module adc_conv_port
  import adc_scan_pkg::*;
#(
  parameter int WIDTH = RES_WIDTH
)
(
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic go, // one-cycle request to convert go_chan
  input wire logic [CHAN_WIDTH-1:0] go_chan, // channel for the request
  input wire logic conv_done, // converter finished, data valid
  input wire logic [WIDTH-1:0] conv_data, // converter result
  output logic conv_start, // sample-and-convert pulse
  output logic [CHAN_WIDTH-1:0] conv_chan, // input multiplexer select
  output logic busy, // conversion outstanding
  output logic [WIDTH-1:0] result, // captured result
  output logic got // one-cycle pulse, result just captured
);

  if (WIDTH < 2 || WIDTH > 16)
  begin : g_bad_width
    $error("adc_conv_port: WIDTH must be 2 to 16");
  end

  wire finish = busy && conv_done;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conv_start <= 1'b0;
      conv_chan <= '0;
      busy <= 1'b0;
      result <= '0;
      got <= 1'b0;
    end
    else
    begin
      conv_start <= go;
      got <= finish;
      if (go)
      begin
        conv_chan <= go_chan;
        busy <= 1'b1;
      end
      else if (finish)
      begin
        busy <= 1'b0;
        result <= conv_data;
      end
    end
  end

endmodule

// file: verilog/adc_limit_check.sv
// per-slot limit and zero-crossing evaluation of one result
`timescale 1ns/1ps
module adc_limit_check
  import adc_scan_pkg::*;
#(
  parameter int WIDTH = RES_WIDTH
)
(
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic clear, // new scan begins, drop old flags
  input wire logic load, // new result for this slot
  input wire logic [WIDTH-1:0] result, // result being loaded
  input wire logic [WIDTH-1:0] low_limit, // below this is out of range
  input wire logic [WIDTH-1:0] high_limit, // above this is out of range
  input wire logic [WIDTH-1:0] zero_level, // crossing reference
  input wire logic [1:0] zc_mode, // crossing condition select
  output logic below, // last result under low limit
  output logic above, // last result over high limit
  output logic crossed // last result crossed the zero level
);

  logic prev_above;
  logic prev_valid;

  // crossing is judged against the previous result of this slot, even across scans
  wire now_above = result >= zero_level;
  wire rise = prev_valid && !prev_above && now_above;
  wire fall = prev_valid && prev_above && !now_above;
  wire next_crossed = (zc_mode == ZC_RISING && rise) || (zc_mode == ZC_FALLING && fall)
    || (zc_mode == ZC_ANY && (rise || fall));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      below <= 1'b0;
      above <= 1'b0;
      crossed <= 1'b0;
      prev_above <= 1'b0;
      prev_valid <= 1'b0;
    end
    else if (load)
    begin
      below <= result < low_limit;
      above <= result > high_limit;
      crossed <= next_crossed;
      prev_above <= now_above;
      prev_valid <= 1'b1;
    end
    else if (clear)
    begin
      below <= 1'b0;
      above <= 1'b0;
      crossed <= 1'b0;
    end
  end

endmodule

// file: verilog/dual_adc_scan_controller.sv
// scan controller for two sample-and-hold paths and two converters
//
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module dual_adc_scan_controller
  import adc_scan_pkg::*;
(
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [ADDR_WIDTH-1:0] addr, // register byte address
  input wire logic [DATA_WIDTH-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [DATA_WIDTH-1:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  input wire logic trig, // scan trigger pulse
  output logic conv_a_start, // path a sample-and-convert pulse
  output logic [CHAN_WIDTH-1:0] conv_a_chan, // path a input select
  input wire logic conv_a_done, // path a converter done
  input wire logic [RES_WIDTH-1:0] conv_a_data, // path a result
  output logic conv_b_start, // path b sample-and-convert pulse
  output logic [CHAN_WIDTH-1:0] conv_b_chan, // path b input select
  input wire logic conv_b_done, // path b converter done
  input wire logic [RES_WIDTH-1:0] conv_b_data // path b result
);

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_ISSUE, ST_CONVERT, ST_CHECK} scan_state_type;
  scan_state_type state, next_state;
  logic [1:0] mode;
  logic simul;
  logic [2:0] last;
  logic limit_en;
  logic zc_en;
  logic [2:0] status;
  logic [2:0] mask;
  logic [LIST_WIDTH-1:0] list;
  logic [15:0] zc_mode;
  logic [RES_WIDTH-1:0] zero_level;
  logic [RES_WIDTH-1:0] result_mem [SLOT_COUNT];
  logic [RES_WIDTH-1:0] low_mem [SLOT_COUNT];
  logic [RES_WIDTH-1:0] high_mem [SLOT_COUNT];
  logic [2:0] slot;
  logic [2:0] owner_a, owner_b;
  logic stop_pend;
  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire ctrl_wr = wr && addr == OFS_CTRL;
  wire status_wr = wr && addr == OFS_STATUS;
  wire mask_wr = wr && addr == OFS_MASK;
  wire list_wr = wr && addr == OFS_LIST;
  wire zc_mode_wr = wr && addr == OFS_ZC_MODE;
  wire zero_wr = wr && addr == OFS_ZERO_LEVEL;
  wire [2:0] word_idx = addr[4:2];
  wire aligned = addr[1:0] == 2'h0;
  wire in_result = aligned && addr[7:5] == OFS_RESULT[7:5];
  wire in_low = aligned && addr[7:5] == OFS_LOW[7:5];
  wire in_high = aligned && addr[7:5] == OFS_HIGH[7:5];
  wire start_req = ctrl_wr && wdata[CTRL_START_POS];
  wire stop_req = ctrl_wr && wdata[CTRL_STOP_POS];
  // ----------------------------------------------------------------
  // scan sequencing
  // ----------------------------------------------------------------
  wire [CHAN_WIDTH-1:0] slot_chan = list[slot*CHAN_WIDTH +: CHAN_WIDTH];
  wire [2:0] pair_slot = slot + 3'h1;
  wire [CHAN_WIDTH-1:0] pair_chan = list[pair_slot*CHAN_WIDTH +: CHAN_WIDTH];
  wire pair_ok = slot < last;
  wire issue = state == ST_ISSUE;
  // channels 0-3 sit on path a, 4-7 on path b when converting one at a time
  wire seq_on_b = slot_chan[CHAN_WIDTH-1];
  // the pair is taken as listed; software keeps the two channels different
  wire go_a = issue && (simul || !seq_on_b);
  wire go_b = issue && (simul ? pair_ok : seq_on_b);
  wire [CHAN_WIDTH-1:0] chan_b = simul ? pair_chan : slot_chan;
  wire [3:0] step = (simul && pair_ok) ? 4'h2 : 4'h1;
  wire [3:0] next_slot = {1'b0, slot} + step;
  wire scan_over = next_slot > {1'b0, last};
  wire a_busy, b_busy, a_got, b_got;
  wire [RES_WIDTH-1:0] a_result, b_result;
  wire conv_idle = !a_busy && !b_busy;
  wire keep_going = mode == MODE_CONTINUOUS && !stop_pend && !stop_req;
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_req)
          next_state = wdata[CTRL_MODE_POS +: 2] == MODE_TRIGGERED ? ST_ARMED : ST_ISSUE;
      ST_ARMED:
        if (stop_req)
          next_state = ST_IDLE;
        else if (trig)
          next_state = ST_ISSUE;
      ST_ISSUE:
        next_state = ST_CONVERT;
      ST_CONVERT:
        if (conv_idle)
          next_state = scan_over ? ST_CHECK : ST_ISSUE;
      ST_CHECK:
        if (keep_going)
          next_state = ST_ISSUE;
        else if (mode == MODE_TRIGGERED && !stop_pend && !stop_req)
          next_state = ST_ARMED;
        else
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      slot <= 3'h0;
      stop_pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stop_pend <= (stop_pend || stop_req) && state != ST_IDLE && next_state != ST_IDLE;
      if (state == ST_CONVERT && conv_idle && !scan_over)
        slot <= next_slot[2:0];
      else if (next_state == ST_IDLE || next_state == ST_ARMED || state == ST_CHECK)
        slot <= 3'h0;
    end
  end
  // ----------------------------------------------------------------
  // converter paths and result buffers
  // ----------------------------------------------------------------
  adc_conv_port #(.WIDTH(RES_WIDTH)) u_path_a
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .go(go_a),
    .go_chan(slot_chan),
    .conv_done(conv_a_done),
    .conv_data(conv_a_data),
    .conv_start(conv_a_start),
    .conv_chan(conv_a_chan),
    .busy(a_busy),
    .result(a_result),
    .got(a_got)
  );
  adc_conv_port #(.WIDTH(RES_WIDTH)) u_path_b
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .go(go_b),
    .go_chan(chan_b),
    .conv_done(conv_b_done),
    .conv_data(conv_b_data),
    .conv_start(conv_b_start),
    .conv_chan(conv_b_chan),
    .busy(b_busy),
    .result(b_result),
    .got(b_got)
  );
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      owner_a <= 3'h0;
      owner_b <= 3'h0;
    end
    else
    begin
      if (go_a)
        owner_a <= slot;
      if (go_b)
        owner_b <= simul ? pair_slot : slot;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (a_got)
      result_mem[owner_a] <= a_result;
    if (b_got)
      result_mem[owner_b] <= b_result;
  end
  // ----------------------------------------------------------------
  // limit and zero-crossing checks
  // ----------------------------------------------------------------
  wire [SLOT_COUNT-1:0] below, above, crossed, in_scan;
  wire scan_clear = issue && slot == 3'h0;
  for (genvar i = 0; i < SLOT_COUNT; i++)
  begin : g_slot
    wire load_a = a_got && owner_a == 3'(i);
    wire load_b = b_got && owner_b == 3'(i);
    assign in_scan[i] = 3'(i) <= last;
    adc_limit_check #(.WIDTH(RES_WIDTH)) u_check
    (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(scan_clear),
      .load(load_a || load_b),
      .result(load_a ? a_result : b_result),
      .low_limit(low_mem[i]),
      .high_limit(high_mem[i]),
      .zero_level(zero_level),
      .zc_mode(zc_mode[2*i +: 2]),
      .below(below[i]),
      .above(above[i]),
      .crossed(crossed[i])
    );
  end
  // results are all in before ST_CHECK, so flags are judged in ST_CHECK, in the same cycle as end of scan
  wire at_check = state == ST_CHECK;
  wire limit_hit = |((below | above) & in_scan);
  wire zc_hit = |(crossed & in_scan);
  wire [2:0] status_set;
  assign status_set[STAT_EOS_POS] = at_check;
  assign status_set[STAT_LIMIT_POS] = at_check && limit_en && limit_hit;
  assign status_set[STAT_ZC_POS] = at_check && zc_en && zc_hit;
  // a set in the same cycle as a write-one-to-clear wins
  wire [2:0] status_clr = status_wr ? wdata[2:0] : 3'h0;
  wire [2:0] next_status = (status & ~status_clr) | status_set;
  wire [2:0] next_mask = mask_wr ? wdata[2:0] : mask;
  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode <= MODE_ONCE;
      simul <= 1'b0;
      last <= LAST_RESET;
      limit_en <= 1'b0;
      zc_en <= 1'b0;
      status <= STATUS_RESET;
      mask <= MASK_RESET;
      list <= LIST_RESET;
      zc_mode <= ZC_MODE_RESET;
      zero_level <= ZERO_LEVEL_RESET;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
      if (ctrl_wr)
      begin
        mode <= wdata[CTRL_MODE_POS +: 2];
        simul <= wdata[CTRL_SIMUL_POS];
        last <= wdata[CTRL_LAST_POS +: 3];
        limit_en <= wdata[CTRL_LIMIT_EN_POS];
        zc_en <= wdata[CTRL_ZC_EN_POS];
      end
      if (list_wr)
        list <= wdata[LIST_WIDTH-1:0];
      if (zc_mode_wr)
        zc_mode <= wdata[15:0];
      if (zero_wr)
        zero_level <= wdata[RES_WIDTH-1:0];
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < SLOT_COUNT; k++)
      begin
        low_mem[k] <= LOW_RESET;
        high_mem[k] <= HIGH_RESET;
      end
    end
    else
    begin
      if (wr && in_low)
        low_mem[word_idx] <= wdata[RES_WIDTH-1:0];
      if (wr && in_high)
        high_mem[word_idx] <= wdata[RES_WIDTH-1:0];
    end
  end
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire scan_busy = state != ST_IDLE && state != ST_ARMED;
  wire [DATA_WIDTH-1:0] ctrl_word = {22'h000000, zc_en, limit_en, last, 2'h0, simul, mode};
  wire [DATA_WIDTH-1:0] status_word = {23'h000000, scan_busy, 5'h00, status};
  wire [DATA_WIDTH-1:0] flags_word = {8'h00, crossed, above, below};
  wire [DATA_WIDTH-1:0] read_word =
    addr == OFS_CTRL ? ctrl_word :
    addr == OFS_STATUS ? status_word :
    addr == OFS_MASK ? {29'h00000000, mask} :
    addr == OFS_LIST ? {8'h00, list} :
    addr == OFS_ZC_MODE ? {16'h0000, zc_mode} :
    addr == OFS_ZERO_LEVEL ? {20'h00000, zero_level} :
    addr == OFS_FLAGS ? flags_word :
    in_result ? {20'h00000, result_mem[word_idx]} :
    in_low ? {20'h00000, low_mem[word_idx]} :
    in_high ? {20'h00000, high_mem[word_idx]} :
    32'h00000000;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else
      rdata <= rd ? read_word : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_issue_starts: assert property (issue |=> conv_a_start || conv_b_start)
    else $error("no converter started after issue");
  a_seq_one_path: assert property (issue && !simul |=> conv_a_start != conv_b_start)
    else $error("sequential issue did not start exactly one path");
  a_simul_pair: assert property (issue && simul && pair_ok |=>
    conv_a_start && conv_b_start && conv_a_chan == $past(slot_chan)
    && conv_b_chan == $past(pair_chan))
    else $error("simultaneous pair not started together");
  a_list_order: assert property (issue && !simul |=>
    (conv_a_start ? conv_a_chan : conv_b_chan) == $past(slot_chan))
    else $error("sequential channel differs from list entry");
  a_result_slot: assert property (a_got |=>
    result_mem[$past(owner_a)] == $past(a_result))
    else $error("path a result not stored in its slot");
  a_once_halts: assert property (at_check && mode == MODE_ONCE |=> state == ST_IDLE)
    else $error("single scan did not halt");
  a_repeat_scan: assert property (at_check && keep_going |=> issue && slot == 3'h0)
    else $error("continuous scan did not restart");
  a_trig_wait: assert property (state == ST_ARMED && !trig |=> !issue)
    else $error("triggered scan began without trigger");
  a_limit_flag: assert property (at_check && limit_en && limit_hit |=>
    status[STAT_LIMIT_POS] && status[STAT_EOS_POS])
    else $error("limit event not flagged at end of scan");
  a_zc_flag: assert property (at_check && zc_en && zc_hit |=> status[STAT_ZC_POS])
    else $error("zero crossing not flagged at end of scan");
  a_eos_after_check: assert property ($rose(status[STAT_EOS_POS]) |-> $past(at_check))
    else $error("end of scan flagged outside check");
  a_irq_follows: assert property (irq == |(status & mask))
    else $error("interrupt output disagrees with status and mask");

  c_once_scan: cover property (at_check && mode == MODE_ONCE);
  c_simul_scan: cover property (at_check && simul && last == 3'h3);
  c_repeat_scan: cover property (at_check && keep_going ##[1:200] at_check);
  c_irq_raised: cover property ($rose(irq) && status[STAT_LIMIT_POS]);

endmodule

// file: test/adc_conv_model.sv
// behavioural converter behind one sample-and-hold path
`timescale 1ns/1ps
module adc_conv_model
  import adc_scan_pkg::*;
#(
  parameter int DELAY = 3
)
(
  input wire logic sys_clk, // system clock
  input wire logic start, // sample-and-convert pulse
  input wire logic [CHAN_WIDTH-1:0] chan, // input select
  input wire logic [8*RES_WIDTH-1:0] levels, // analog level of each input
  output logic done, // conversion finished
  output logic [RES_WIDTH-1:0] data // result, valid only with done
);
  int count = 0;
  logic [RES_WIDTH-1:0] held = 12'h000;
  initial done = 1'b0;
  initial data = 12'h000;
  always @(posedge sys_clk)
  begin
    done <= 1'b0;
    // toggling so a stale result is never mistaken for a fresh one
    data <= ~data;
    if (start)
    begin
      held <= levels[chan*RES_WIDTH +: RES_WIDTH];
      count <= DELAY;
    end
    else if (count == 1)
    begin
      done <= 1'b1;
      data <= held;
      count <= 0;
    end
    else if (count > 1)
      count <= count - 1;
  end
endmodule

// file: test/dual_adc_scan_controller_bench.sv
// self-checking bench of the dual converter scan controller
`timescale 1ns/1ps
module dual_adc_scan_controller_bench
  import adc_scan_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_WIDTH-1:0] addr = 8'h00;
  logic [DATA_WIDTH-1:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trig = 1'b0;
  logic [DATA_WIDTH-1:0] rdata, rv;
  logic irq, conv_a_start, conv_b_start, conv_a_done, conv_b_done;
  logic [CHAN_WIDTH-1:0] conv_a_chan, conv_b_chan;
  logic [RES_WIDTH-1:0] conv_a_data, conv_b_data;
  logic [8*RES_WIDTH-1:0] levels;
  int failures = 0;
  int checks_done = 0;
  int pairs = 0;
  int na = 0;
  int nb = 0;
  int cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  dual_adc_scan_controller DUT (.sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .trig,
    .conv_a_start, .conv_a_chan, .conv_a_done, .conv_a_data,
    .conv_b_start, .conv_b_chan, .conv_b_done, .conv_b_data);
  // the two paths answer at different speeds
  adc_conv_model #(.DELAY(3)) conv_a (.sys_clk, .start(conv_a_start), .chan(conv_a_chan),
    .levels, .done(conv_a_done), .data(conv_a_data));
  adc_conv_model #(.DELAY(7)) conv_b (.sys_clk, .start(conv_b_start), .chan(conv_b_chan),
    .levels, .done(conv_b_done), .data(conv_b_data));

  always @(posedge sys_clk)
  begin
    if (conv_a_start && conv_b_start && conv_a_chan != conv_b_chan)
      pairs++;
    na += int'(conv_a_start);
    nb += int'(conv_b_start);
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // ------
  // bus tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rv, exp);
  endtask
  // bounded poll of one status bit
  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 300; i++)
    begin
      rd_reg(OFS_STATUS);
      if (rv[b] === v)
        return;
    end
    chk(rv[b], v);
  endtask
  task automatic fire;
    @(posedge sys_clk);
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
  endtask
  function automatic logic [31:0] lvl(input int c);
    return {20'h0, levels[c*RES_WIDTH +: RES_WIDTH]};
  endfunction
  task automatic end_sim;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------
  // scenarios
  // ------
  initial
  begin
    for (int c = 0; c < 8; c++)
      levels[c*RES_WIDTH +: RES_WIDTH] = 12'h123 + 12'(c) * 12'h111;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(OFS_CTRL, 32'h000000E0);
    rd_chk(OFS_LIST, 32'h00FAC688);
    rd_chk(OFS_ZERO_LEVEL, 32'h00000800);
    rd_chk(OFS_HIGH + 8'h0C, 32'h00000FFF);
    wr_reg(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h00000000);
    // reversed list, with one result under its low and one over its high limit
    wr_reg(OFS_LIST, 32'h00053977);
    wr_reg(OFS_LOW + 8'h08, lvl(5) + 32'h1);
    wr_reg(OFS_HIGH + 8'h14, lvl(2) - 32'h1);
    wr_reg(OFS_MASK, 32'h00000002);
    na = 0;
    nb = 0;
    wr_reg(OFS_CTRL, 32'h000001E8);
    wait_bit(STAT_EOS_POS, 1'b1);
    for (int s = 0; s < 8; s++)
      rd_chk(OFS_RESULT + 8'(4 * s), lvl(7 - s));
    chk(32'(na), 32'h4);
    chk(32'(nb), 32'h4);
    rd_chk(OFS_STATUS, 32'h00000003);
    chk(irq, 1'b1);
    rd_chk(OFS_FLAGS, 32'h00002004);
    wr_reg(OFS_RESULT, 32'h00000000);
    rd_chk(OFS_RESULT, lvl(7));
    wr_reg(OFS_STATUS, 32'h00000007);
    rd_chk(OFS_STATUS, 32'h00000000);
    chk(irq, 1'b0);
    // simultaneous pairs of distinct channels
    levels = ~levels;
    pairs = 0;
    wr_reg(OFS_CTRL, 32'h0000006C);
    wait_bit(STAT_EOS_POS, 1'b1);
    chk(32'(pairs), 32'h2);
    for (int s = 0; s < 4; s++)
      rd_chk(OFS_RESULT + 8'(4 * s), lvl(7 - s));
    wr_reg(OFS_STATUS, 32'h00000007);
    // triggered scans; slot 0 rises through the zero level on the second
    wr_reg(OFS_ZC_MODE, 32'h00000001);
    wr_reg(OFS_MASK, 32'h00000004);
    wr_reg(OFS_CTRL, 32'h00000209);
    repeat (20) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 32'h00000000);
    fire();
    wait_bit(STAT_EOS_POS, 1'b1);
    rd_chk(OFS_STATUS, 32'h00000001);
    wr_reg(OFS_STATUS, 32'h00000007);
    levels[7*RES_WIDTH +: RES_WIDTH] = 12'h900;
    fire();
    wait_bit(STAT_EOS_POS, 1'b1);
    rd_chk(OFS_STATUS, 32'h00000005);
    chk(irq, 1'b1);
    rd_reg(OFS_FLAGS);
    chk(rv & 32'h00010101, 32'h00010000);
    wr_reg(OFS_CTRL, 32'h00000010);
    wr_reg(OFS_STATUS, 32'h00000007);
    fire();
    repeat (20) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 32'h00000000);
    // continuous until stopped
    wr_reg(OFS_CTRL, 32'h0000000A);
    wait_bit(STAT_EOS_POS, 1'b1);
    wr_reg(OFS_STATUS, 32'h00000007);
    wait_bit(STAT_EOS_POS, 1'b1);
    wr_reg(OFS_CTRL, 32'h00000010);
    wait_bit(STAT_BUSY_POS, 1'b0);
    wr_reg(OFS_STATUS, 32'h00000007);
    repeat (20) @(posedge sys_clk);
    rd_chk(OFS_STATUS, 32'h00000000);
    // slot 0 falls under either-way crossing, slot 1 under falling-only
    levels[7*RES_WIDTH +: RES_WIDTH] = 12'h700;
    levels[6*RES_WIDTH +: RES_WIDTH] = 12'h100;
    wr_reg(OFS_ZC_MODE, 32'h0000000B);
    wr_reg(OFS_CTRL, 32'h00000228);
    wait_bit(STAT_EOS_POS, 1'b1);
    rd_chk(OFS_STATUS, 32'h00000005);
    rd_chk(OFS_FLAGS, 32'h00030000);
    rd_chk(OFS_RESULT + 8'h04, lvl(6));
    rd_chk(OFS_RESULT, lvl(7));
    end_sim();
  end
endmodule
